// ==== rtl/sfap_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: six reserved, nine page, nine byte bits
// RULE2: 0b/d4 one dummy, d2/e8 four
// RULE3: field use depends on opcode
// RULE4: status/id/power opcodes take no address
// RULE5: default to mode 3 after reset
// RULE6: serial output high impedance after reset
// RULE7: command starts only on select fall
// RULE8: idle clock level picks mode per select
// RULE9: ignore everything while reset holds
// RULE10: host waits 50 us before select
// RULE11: no write within 20 ms of power-up
// RULE12: standby state after power-up
// RULE13: opcode then address, msb first
module sfap_device (
    input  wire logic                        i_mclk,
    input  wire logic                        i_sys_rst,
    sfap_if.dev                              bus,
    output logic                             o_cmd_valid,
    output logic [7:0]                       o_opcode,
    output logic [sfap_pkg::PAGE_BITS-1:0]   o_page,
    output logic [sfap_pkg::BYTE_BITS-1:0]   o_byte,
    output logic                             o_mode3,
    output logic                             o_standby,
    output logic                             o_write_ok,
    output logic                             o_write_refused
);
    import sfap_pkg::*;

    typedef enum logic [1:0] {
        SFAP_ST_IDLE  = 2'h0,
        SFAP_ST_OP    = 2'h1,
        SFAP_ST_ADDR  = 2'h2,
        SFAP_ST_DUMMY = 2'h3
    } sfap_st_e;

    typedef struct packed {
        logic [2:0]              cs_s;
        logic [2:0]              sck_s;
        logic [1:0]              si_s;
        sfap_st_e                st;
        logic                    mode3;
        logic [5:0]              bitcnt;
        logic [7:0]              op;
        logic [ADDR_BITS-1:0]    addr;
        logic [2:0]              dummy;
        logic                    valid;
        logic [7:0]              op_out;
        logic [PAGE_BITS-1:0]    page;
        logic [BYTE_BITS-1:0]    byt;
        logic [24:0]             wr_cnt;
        logic                    wr_ok;
        logic                    refused;
    } sfap_dev_s;

    sfap_dev_s s_q;
    sfap_dev_s s_d;
    logic      cs_fall;
    logic      sck_rise;
    logic      shift_bit;
    logic [7:0] op_now;
    logic [ADDR_BITS-1:0] addr_now;

    // ignored fields read as zero, so a stale address never leaks through
    function automatic logic [PAGE_BITS+BYTE_BITS-1:0] sfap_fields(
        input logic [7:0]           op,
        input logic [ADDR_BITS-1:0] a
    );
        logic [PAGE_BITS-1:0] pg;
        logic [BYTE_BITS-1:0] by;
        pg = a[PAGE_MSB_POS -: PAGE_BITS];
        by = '0;
        // page-only opcodes fall to the default and drop the byte field
        case (op)
            OP_BUF_WR, OP_BUF_RD_HI, 8'hd1: begin
                pg = '0;
                by = a[BYTE_MSB_POS -: BYTE_BITS];
            end
            OP_BLK_ERASE: begin
                pg = {a[PAGE_MSB_POS -: 5], 4'h0};
            end
            OP_SEC_RD, OP_SEC_ERASE: begin
                pg = '0;
            end
            8'h03, 8'h82, OP_READ_CONT, OP_PAGE_RD, OP_CONT_LEG: begin
                by = a[BYTE_MSB_POS -: BYTE_BITS];
            end
            default: begin
                by = '0;
            end
        endcase
        return {pg, by}; // RULE3
    endfunction

    always_comb begin
        s_d         = s_q;
        s_d.cs_s    = {s_q.cs_s[1:0], bus.cs_n};
        s_d.sck_s   = {s_q.sck_s[1:0], bus.sck};
        s_d.si_s    = {s_q.si_s[0], bus.si};
        s_d.valid   = 1'b0;
        s_d.refused = 1'b0;
        cs_fall     = s_q.cs_s[2] && !s_q.cs_s[1]; // RULE7
        sck_rise    = !s_q.sck_s[2] && s_q.sck_s[1];
        shift_bit   = s_q.si_s[1];
        op_now      = {s_q.op[6:0], shift_bit}; // RULE13
        addr_now    = {s_q.addr[ADDR_BITS-2:0], shift_bit};
        // full delay always, never shortened for tests
        if (s_q.wr_cnt != WR_DELAY_CYC[24:0]) begin
            s_d.wr_cnt = s_q.wr_cnt + 25'h1; // RULE11
        end else begin
            s_d.wr_ok = 1'b1;
        end
        // a frame cut by select rising is simply dropped
        if (s_q.cs_s[1]) begin
            s_d.st = SFAP_ST_IDLE;
        end else if (cs_fall) begin
            s_d.mode3  = s_q.sck_s[1]; // RULE8
            s_d.st     = SFAP_ST_OP;
            s_d.bitcnt = 6'h0;
        end else if (sck_rise) begin
            case (s_q.st)
                SFAP_ST_OP: begin
                    s_d.op     = op_now;
                    s_d.bitcnt = s_q.bitcnt + 6'h1;
                    if (s_q.bitcnt == 6'h7) begin
                        s_d.bitcnt = 6'h0;
                        if (sfap_has_addr(op_now)) begin
                            s_d.st = SFAP_ST_ADDR;
                        end else begin
                            s_d.st     = SFAP_ST_IDLE; // RULE4
                            s_d.valid  = 1'b1;
                            s_d.op_out = op_now;
                            s_d.page   = '0;
                            s_d.byt    = '0;
                        end
                    end
                end
                SFAP_ST_ADDR: begin
                    s_d.addr   = addr_now;
                    s_d.bitcnt = s_q.bitcnt + 6'h1;
                    if (s_q.bitcnt == 6'(ADDR_BITS - 1)) begin
                        s_d.bitcnt = 6'h0;
                        s_d.op_out = s_q.op;
                        {s_d.page, s_d.byt} = sfap_fields(s_q.op, addr_now); // RULE1 RULE3
                        s_d.dummy = sfap_dummy(s_q.op); // RULE2
                        if (sfap_dummy(s_q.op) != 3'h0) begin
                            s_d.st = SFAP_ST_DUMMY;
                        end else begin
                            s_d.st = SFAP_ST_IDLE;
                            // refused writes still show their fields
                            if (sfap_is_write(s_q.op) && !s_q.wr_ok) begin
                                s_d.refused = 1'b1; // RULE11
                            end else begin
                                s_d.valid = 1'b1;
                            end
                        end
                    end
                end
                // stray rises after a finished command are ignored
                SFAP_ST_IDLE: begin
                    s_d.st = SFAP_ST_IDLE;
                end
                // dummy bytes are counted, never stored
                SFAP_ST_DUMMY: begin
                    s_d.bitcnt = s_q.bitcnt + 6'h1;
                    if (s_q.bitcnt[2:0] == 3'h7) begin
                        s_d.dummy = s_q.dummy - 3'h1;
                        if (s_q.dummy == 3'h1) begin
                            s_d.st    = SFAP_ST_IDLE;
                            s_d.valid = 1'b1;
                        end
                    end
                end
                default: begin
                    s_d.st = SFAP_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s_q       <= '0; // RULE9
            // select sync resets low: a select held low through reset is no edge
            s_q.sck_s <= 3'h7;
            s_q.mode3 <= MODE_RESET; // RULE5
            s_q.st    <= SFAP_ST_IDLE; // RULE12
        end else begin
            s_q <= s_d;
        end
    end

    // no read path here, so the output stays released
    assign bus.so          = 1'b0;
    assign bus.so_oe_n     = 1'b1; // RULE6
    assign o_cmd_valid     = s_q.valid;
    assign o_opcode        = s_q.op_out;
    assign o_page          = s_q.page;
    assign o_byte          = s_q.byt;
    assign o_mode3         = s_q.mode3;
    assign o_standby       = (s_q.st == SFAP_ST_IDLE); // RULE12
    assign o_write_ok      = s_q.wr_ok;
    assign o_write_refused = s_q.refused;
endmodule
`default_nettype wire

// ==== shared/sfap_pkg.sv ====
package sfap_pkg;
    localparam int unsigned MCLK_HZ          = 20000000;
    localparam int unsigned SEL_DELAY_US     = 50;
    localparam int unsigned WR_DELAY_MS      = 20;
    localparam int unsigned SEL_DELAY_CYC    = (SEL_DELAY_US * (MCLK_HZ / 1000000));
    localparam int unsigned WR_DELAY_CYC     = (WR_DELAY_MS * (MCLK_HZ / 1000));
    localparam int unsigned SCK_HALF_CYC     = 4;
    localparam int unsigned RSV_BITS         = 6;
    localparam int unsigned PAGE_BITS        = 9;
    localparam int unsigned BYTE_BITS        = 9;
    localparam int unsigned PAGE_MSB_POS     = 17;
    localparam int unsigned BYTE_MSB_POS     = 8;
    localparam int unsigned ADDR_BITS        = 24;
    localparam logic [2:0]  ADDR_BYTES       = 3'h3;
    localparam logic [2:0]  DUMMY_ONE        = 3'h1;
    localparam logic [2:0]  DUMMY_FOUR       = 3'h4;
    localparam logic        MODE_RESET       = 1'h1;

    localparam logic [7:0] OP_READ_CONT  = 8'h0b;
    localparam logic [7:0] OP_BUF_RD_HI  = 8'hd4;
    localparam logic [7:0] OP_PAGE_RD    = 8'hd2;
    localparam logic [7:0] OP_CONT_LEG   = 8'he8;
    localparam logic [7:0] OP_PG_XFER    = 8'h53;
    localparam logic [7:0] OP_BUF_WR     = 8'h84;
    localparam logic [7:0] OP_BLK_ERASE  = 8'h50;
    localparam logic [7:0] OP_SEC_RD     = 8'h77;
    localparam logic [7:0] OP_SEC_ERASE  = 8'h7c;
    localparam logic [7:0] OP_ID_READ    = 8'h9f;
    localparam logic [7:0] OP_DEEP_PD    = 8'hb9;
    localparam logic [7:0] OP_RESUME     = 8'hab;
    localparam logic [7:0] OP_STATUS     = 8'hd7;

    typedef enum logic [1:0] {
        SFAP_KIND_PAGE = 2'h0,
        SFAP_KIND_BUF  = 2'h1,
        SFAP_KIND_BOTH = 2'h2,
        SFAP_KIND_NONE = 2'h3
    } sfap_kind_e;

    function automatic logic sfap_has_addr(input logic [7:0] op);
        return !(op == OP_ID_READ || op == OP_DEEP_PD || op == OP_RESUME || op == OP_STATUS);
    endfunction

    function automatic logic [2:0] sfap_dummy(input logic [7:0] op);
        if (op == OP_READ_CONT || op == OP_BUF_RD_HI) begin
            return DUMMY_ONE;
        end
        if (op == OP_PAGE_RD || op == OP_CONT_LEG) begin
            return DUMMY_FOUR;
        end
        return 3'h0;
    endfunction

    function automatic logic sfap_is_write(input logic [7:0] op);
        return op == 8'h82 || op == 8'h83 || op == 8'h88 || op == OP_BLK_ERASE
            || op == 8'h81 || op == 8'h58 || op == OP_SEC_ERASE || op == OP_BUF_WR;
    endfunction
endpackage

// ==== shared/sfap_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sfap_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe_n;
    modport host (output cs_n, output sck, output si, input so, input so_oe_n);
    modport dev  (input cs_n, input sck, input si, output so, output so_oe_n);
endinterface
`default_nettype wire

// ==== rtl/sfap_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfap_host #(
    parameter int unsigned WR_WAIT = sfap_pkg::WR_DELAY_CYC
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_sys_rst,
    sfap_if.host                             bus,
    input  wire logic                        i_req,
    input  wire logic [7:0]                  i_opcode,
    input  wire logic [sfap_pkg::PAGE_BITS-1:0] i_page,
    input  wire logic [sfap_pkg::BYTE_BITS-1:0] i_byte,
    input  wire logic                        i_mode3,
    output logic                             o_ready,
    output logic                             o_done
);
    import sfap_pkg::*;

    // one counter serves both power-up delays, so it runs to the longer one
    localparam int unsigned CNT_TOP = (WR_WAIT > SEL_DELAY_CYC) ? WR_WAIT : SEL_DELAY_CYC;

    typedef enum logic [1:0] {
        SFAP_H_WAIT  = 2'h0,
        SFAP_H_IDLE  = 2'h1,
        SFAP_H_SHIFT = 2'h2,
        SFAP_H_END   = 2'h3
    } sfap_h_e;

    typedef struct packed {
        sfap_h_e      st;
        logic [24:0]  cnt;
        logic         wr_ok;
        logic         cs_n;
        logic         sck;
        logic         idle_sck;
        logic [63:0]  sh;
        logic [6:0]   bits;
        logic [2:0]   half;
        logic         done;
    } sfap_host_s;

    sfap_host_s s_q;
    sfap_host_s s_d;
    logic [6:0] nbits;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        nbits    = 7'h8;
        if (sfap_has_addr(i_opcode)) begin
            nbits = 7'(32 + 8 * sfap_dummy(i_opcode));
        end
        if (s_q.cnt != CNT_TOP[24:0]) begin
            s_d.cnt = s_q.cnt + 25'h1;
        end
        if (s_q.cnt >= WR_WAIT[24:0]) begin
            s_d.wr_ok = 1'b1; // RULE11
        end
        case (s_q.st)
            SFAP_H_WAIT: begin
                if (s_q.cnt >= SEL_DELAY_CYC[24:0]) begin
                    s_d.st = SFAP_H_IDLE; // RULE10
                end
            end
            SFAP_H_IDLE: begin
                if (i_req && (s_q.wr_ok || !sfap_is_write(i_opcode))) begin
                    s_d.idle_sck = i_mode3;
                    s_d.sck      = i_mode3;
                    // RULE13 RULE1
                    s_d.sh   = {i_opcode, 6'h0, i_page, i_byte, 32'h0};
                    s_d.bits = nbits;
                    s_d.half = 3'h0;
                    s_d.st   = SFAP_H_SHIFT;
                end
            end
            SFAP_H_SHIFT: begin
                s_d.half = s_q.half + 3'h1;
                if (s_q.half == 3'(SCK_HALF_CYC - 1)) begin
                    s_d.half = 3'h0;
                    if (s_q.cs_n) begin
                        // clock already sits at its idle level here
                        s_d.cs_n = 1'b0; // RULE7
                    end else begin
                        s_d.sck = !s_q.sck;
                        // data moves on the falling edge
                        if (s_q.sck && s_q.bits != nbits) begin
                            s_d.sh = {s_q.sh[62:0], 1'b0};
                        end
                        if (!s_q.sck) begin
                            s_d.bits = s_q.bits - 7'h1;
                        end
                        // mode 0 needs one more falling edge to get back to idle
                        if (s_d.bits == 7'h0 && s_d.sck == s_q.idle_sck) begin
                            s_d.st = SFAP_H_END; // RULE2
                        end
                    end
                end
            end
            SFAP_H_END: begin
                s_d.half = s_q.half + 3'h1;
                s_d.sck  = s_q.idle_sck;
                if (s_q.half == 3'(SCK_HALF_CYC - 1)) begin
                    s_d.cs_n = 1'b1;
                    s_d.done = 1'b1;
                    s_d.half = 3'h0;
                    s_d.st   = SFAP_H_IDLE;
                end
            end
            default: begin
                s_d.st = SFAP_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s_q      <= '0;
            s_q.cs_n <= 1'b1;
            s_q.sck  <= MODE_RESET;
            s_q.st   <= SFAP_H_WAIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.cs_n = s_q.cs_n;
    assign bus.sck  = s_q.sck;
    assign bus.si   = s_q.sh[63];
    assign o_ready  = (s_q.st == SFAP_H_IDLE) && (s_q.wr_ok || !sfap_is_write(i_opcode));
    assign o_done   = s_q.done;
endmodule
`default_nettype wire

// ==== testbench/sfap_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfap_properties #(
    parameter int unsigned WR_WAIT = sfap_pkg::WR_DELAY_CYC
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n
);
    import sfap_pkg::*;
    logic        sck_q;
    logic        idle_q;
    logic [6:0]  rise_q;
    logic [7:0]  op_q;
    int unsigned up_q;

    // rising link clock edges per frame: opcode, address, dummies
    function automatic logic [6:0] frame_len(input logic [7:0] op);
        case (op)
            8'h9f, 8'hb9, 8'hab, 8'hd7: return 7'h08;
            8'h0b, 8'hd4: return 7'h28;
            8'hd2, 8'he8: return 7'h40;
            default: return 7'h20;
        endcase
    endfunction

    function automatic logic is_wr(input logic [7:0] op);
        return op inside {8'h81, 8'h82, 8'h83, 8'h88, 8'h50, 8'h58, 8'h7c, 8'h84};
    endfunction

    // link clock is slow enough to be sampled like data
    always_ff @(posedge i_mclk) begin
        sck_q <= sck;
        up_q  <= i_sys_rst ? 0 : up_q + 1;
        if (cs_n) begin
            idle_q <= sck;
        end
        if (i_sys_rst || cs_n) begin
            rise_q <= 7'h0;
        end else if (sck && !sck_q) begin
            rise_q <= rise_q + 7'h1;
            op_q   <= (rise_q < 7'h8) ? {op_q[6:0], si} : op_q;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence sck_hold_s;
        $stable(sck) [*3];
    endsequence
    sequence frame_end_s;
        $rose(cs_n);
    endsequence

    so_hiz_a: assert property (so_oe_n) else $error("serial output enabled");
    rst_idle_a: assert property ($fell(i_sys_rst) |-> cs_n && sck)
        else $error("link not idle after reset");
    sel_fall_a: assert property ($fell(cs_n) |-> $stable(sck))
        else $error("clock moved at select");
    half_period_a: assert property (!cs_n && $changed(sck) |=> sck_hold_s)
        else $error("clock half period short");
    frame_len_a: assert property (frame_end_s |-> rise_q == frame_len(op_q))
        else $error("frame length wrong for opcode");
    idle_level_a: assert property (frame_end_s |-> sck == idle_q)
        else $error("clock not back at idle level");
    select_delay_a: assert property ($fell(cs_n) |-> up_q >= SEL_DELAY_CYC)
        else $error("select too soon after reset");
    write_delay_a: assert property (frame_end_s |-> !is_wr(op_q) || up_q >= WR_WAIT)
        else $error("write too soon after reset");
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sfap_pkg::*;
    localparam int unsigned WR_WAIT = 200;
    typedef struct packed {
        logic [7:0] op;
        logic       m3;
        logic       wr;
        logic [8:0] pg;
        logic [8:0] by;
    } sfap_row_s;
    logic       i_mclk    = 1'h0;
    logic       i_sys_rst = 1'h1;
    logic       rst2      = 1'h1;
    logic       i_req     = 1'h0;
    logic [7:0] i_opcode  = 8'h0;
    logic       i_mode3   = 1'h1;
    logic       o_ready, o_done, o_cmd_valid, o_mode3, o_standby, o_write_ok, o_write_refused;
    logic       v2;
    logic [7:0] o_opcode, op2;
    logic [8:0] o_page, o_byte, pg2, by2;
    int         num_errors = 0;
    int         tests_run  = 0;
    int         cyc        = 0;
    int         nval       = 0;
    int         nv2        = 0;
    int         n0;
    sfap_if bus ();
    sfap_if bus2 ();
    // page input 1a5, byte input 0c3 on every row
    sfap_row_s rows [17] = '{
        '{8'h03, 1'h1, 1'h0, 9'h1a5, 9'h0c3}, '{8'h0b, 1'h0, 1'h0, 9'h1a5, 9'h0c3},
        '{8'hd4, 1'h1, 1'h0, 9'h000, 9'h0c3}, '{8'hd2, 1'h0, 1'h0, 9'h1a5, 9'h0c3},
        '{8'he8, 1'h1, 1'h0, 9'h1a5, 9'h0c3}, '{8'h53, 1'h0, 1'h0, 9'h1a5, 9'h000},
        '{8'h60, 1'h1, 1'h0, 9'h1a5, 9'h000}, '{8'h77, 1'h0, 1'h0, 9'h000, 9'h000},
        '{8'hd1, 1'h1, 1'h0, 9'h000, 9'h0c3}, '{8'h9f, 1'h0, 1'h0, 9'h000, 9'h000},
        '{8'hd7, 1'h1, 1'h0, 9'h000, 9'h000}, '{8'hb9, 1'h0, 1'h0, 9'h000, 9'h000},
        '{8'hab, 1'h1, 1'h0, 9'h000, 9'h000}, '{8'h82, 1'h0, 1'h1, 9'h1a5, 9'h0c3},
        '{8'h50, 1'h1, 1'h1, 9'h1a0, 9'h000}, '{8'h84, 1'h1, 1'h1, 9'h000, 9'h0c3},
        '{8'h7c, 1'h0, 1'h1, 9'h000, 9'h000}};

    sfap_host #(.WR_WAIT(WR_WAIT)) sfap_host_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .bus(bus.host), .i_req(i_req), .i_opcode(i_opcode), .i_page(9'h1a5),
        .i_byte(9'h0c3), .i_mode3(i_mode3), .o_ready(o_ready), .o_done(o_done));
    sfap_device sfap_device_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus.dev),
        .o_cmd_valid(o_cmd_valid), .o_opcode(o_opcode), .o_page(o_page), .o_byte(o_byte),
        .o_mode3(o_mode3), .o_standby(o_standby), .o_write_ok(o_write_ok),
        .o_write_refused(o_write_refused));
    // second device faces the bench, which breaks the host's side on purpose
    sfap_device sfap_device_2_i (.i_mclk(i_mclk), .i_sys_rst(rst2), .bus(bus2.dev),
        .o_cmd_valid(v2), .o_opcode(op2), .o_page(pg2), .o_byte(by2), .o_mode3(),
        .o_standby(), .o_write_ok(), .o_write_refused());
    sfap_properties #(.WR_WAIT(WR_WAIT)) sfap_properties_i (.i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst), .cs_n(bus.cs_n), .sck(bus.sck), .si(bus.si),
        .so(bus.so), .so_oe_n(bus.so_oe_n));

    always #25 i_mclk = ~i_mclk;

    task automatic results();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cyc++;
        nval += (o_cmd_valid === 1'h1);
        nv2 += (v2 === 1'h1);
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask

    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask

    task automatic issue(input sfap_row_s r);
        for (int n = 0; n < 5000 && o_ready !== 1'h1; n++) tick(1);
        i_req = 1'h1;
        i_opcode = r.op;
        i_mode3 = r.m3;
        tick(1);
        i_req = 1'h0;
    endtask

    task automatic run_row(input sfap_row_s r);
        logic gv, gr, gd;
        gv = 1'h0;
        gr = 1'h0;
        gd = 1'h0;
        issue(r);
        for (int n = 0; n < 3000 && !(gd && (gv || gr)); n++) begin
            gv |= (o_cmd_valid === 1'h1);
            gr |= (o_write_refused === 1'h1);
            gd |= (o_done === 1'h1);
            tick(1);
        end
        tick(4);
        chk_bit(gv, !r.wr, "framed");
        chk_bit(gr, r.wr, "write refusal");
        chk_bit(o_mode3, r.m3, "mode");
        chk_bit(o_standby, 1'h1, "standby");
        chk_val({1'h0, o_opcode}, {1'h0, r.op}, "opcode");
        chk_val(o_page, r.pg, "page");
        chk_val(o_byte, r.by, "byte");
    endtask

    // bench-made link clock, 400 ns period, mode 3 idle high
    task automatic bang(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            bus2.sck = 1'h0;
            bus2.si = v[i];
            #200 bus2.sck = 1'h1;
            #200;
        end
        bus2.si = ~bus2.si;
    endtask

    initial begin
        bus2.cs_n = 1'h1;
        bus2.sck = 1'h1;
        bus2.si = 1'h0;
        tick(3);
        i_sys_rst = 1'h0;
        tick(1);
        chk_bit(o_mode3, 1'h1, "mode after reset");
        chk_bit(bus.so_oe_n, 1'h1, "output released");
        chk_bit(o_ready, 1'h0, "host held off");
        chk_bit(o_write_ok, 1'h0, "writes held off");
        bus2.cs_n = 1'h0;
        #200;
        bang({8'h77, 24'h0}, 32);
        tick(2);
        rst2 = 1'h0;
        tick(10);
        bang({8'h77, 24'h0}, 32);
        tick(10);
        chk_val(nv2[8:0], 9'h0, "frames ignored");
        bus2.cs_n = 1'h1;
        #400 bus2.cs_n = 1'h0;
        #200;
        bang({8'h03, 6'h3f, 9'h1a5, 9'h0c3}, 32);
        #200 bus2.cs_n = 1'h1;
        tick(10);
        chk_val(nv2[8:0], 9'h1, "frame after select");
        chk_val({1'h0, op2}, 9'h003, "opcode order");
        chk_val(pg2, 9'h1a5, "page field");
        chk_val(by2, 9'h0c3, "byte field");
        foreach (rows[k]) run_row(rows[k]);
        // reset in mid-frame: the frame must vanish and mode fall back
        issue(rows[3]);
        n0 = nval;
        tick(100);
        i_sys_rst = 1'h1;
        tick(3);
        i_sys_rst = 1'h0;
        tick(1);
        chk_bit(o_mode3, 1'h1, "mode after second reset");
        tick(600);
        chk_val(9'(nval - n0), 9'h0, "aborted frame");
        run_row(rows[0]);
        chk_bit(o_write_ok, 1'h0, "still before write delay");
        results();
    end
endmodule
`default_nettype wire
